/* rtl/angle_readout_defines.svh */
// constants for the angle sensor readout block
`ifndef ANGLE_READOUT_DEFINES_SVH
`define ANGLE_READOUT_DEFINES_SVH
`define CLK_MHZ           125
`define BASE_PERIOD_US    25
`define BASE_PERIOD_CYC   (`BASE_PERIOD_US * `CLK_MHZ)
`define INIT_TIME_US      300
`define INIT_TIME_CYC     (`INIT_TIME_US * `CLK_MHZ)
`define REG_ANGLE         4'h0
`define REG_STATUS        4'h1
`define REG_CTRL          4'h2
`define REG_REF_ANGLE     4'h3
`define CTRL_SLOW_BIT     2
`define ADDR_ANGLE        4'h0
`define ADDR_CTRL         4'h4
`define ADDR_STATUS       4'h8
`define ADDR_REF          4'hC
`define AVERAGING_RESET   3'h3
`endif

/* rtl/angle_readout_pkg.sv */
// types for the angle sensor readout block
package angle_readout_pkg;
  typedef struct packed {
    logic supply_low;
    logic internal_fault_flag;
    logic magnet_lost_flag;
    logic nvm_corrected;
    logic nvm_uncorrectable;
    logic battery_loss_flag;
  } diag_s;
  typedef enum logic [1:0] {ST_INIT, ST_RUN} phase_e;
endpackage

/* rtl/angle_sensor_readout.sv */
// angle sensor readout: sampling, diagnostics, spi slave and avalon registers
//
// Design decisions made here: the address map and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`include "angle_readout_defines.svh"
module angle_sensor_readout #(
  parameter int          INIT_CYC   = `INIT_TIME_CYC,
  parameter int          BASE_CYC   = `BASE_PERIOD_CYC,
  parameter int          WDOG_CYC   = 8 * `BASE_PERIOD_CYC,
  parameter logic [12:0] NVM_REF    = 13'h0000,
  parameter logic        NVM_SLOW   = 1'b0,
  parameter logic [2:0]  NVM_AVERAGING = `AVERAGING_RESET
) (
  // clock and reset
  input  wire logic        MCLK_I,
  input  wire logic        NRST_I,
  input  wire logic        CE_I,
  // front end
  input  wire logic [12:0] RAW_ANGLE_I,
  input  wire logic        CONV_TICK_I,
  input  wire logic        FIELD_LOW_I,
  input  wire logic        SUPPLY_GOOD_I,
  input  wire logic        SUPPLY_LOW_I,
  input  wire logic        BATTERY_LOST_I,
  input  wire logic        NVM_CORR_I,
  input  wire logic        NVM_UNCORR_I,
  // spi pins
  input  wire logic        SCLK_I,
  input  wire logic        CS_N_I,
  input  wire logic        MOSI_I,
  output logic             MISO_O,
  output logic             MISO_OE_O,
  // avalon-mm slave
  input  wire logic [3:0]  AVS_ADDRESS_I,
  input  wire logic        AVS_READ_I,
  input  wire logic        AVS_WRITE_I,
  input  wire logic [31:0] AVS_WRITEDATA_I,
  output logic [31:0]      AVS_READDATA_O,
  output logic             AVS_WAITREQUEST_O,
  // status
  output logic             READY_O,
  output logic             SLOW_MODE_O
);

  // pin synchronisers
  logic [1:0] sclk_sy_ff;
  logic [1:0] cs_sy_ff;
  logic [1:0] mosi_sy_ff;
  logic [1:0] sg_sy_ff;
  logic [4:0] async_sy_ff;
  logic [4:0] async_q_ff;
  logic       sclk_d_ff;

  always_ff @(posedge MCLK_I or negedge NRST_I)
  begin
    if (!NRST_I)
    begin
      sclk_sy_ff  <= 2'h0;
      cs_sy_ff    <= 2'h3;
      mosi_sy_ff  <= 2'h0;
      sg_sy_ff    <= 2'h0;
      async_sy_ff <= 5'h00;
      async_q_ff  <= 5'h00;
      sclk_d_ff   <= 1'b0;
    end
    else if (CE_I)
    begin
      sclk_sy_ff  <= {sclk_sy_ff[0], SCLK_I};
      cs_sy_ff    <= {cs_sy_ff[0], CS_N_I};
      mosi_sy_ff  <= {mosi_sy_ff[0], MOSI_I};
      sg_sy_ff    <= {sg_sy_ff[0], SUPPLY_GOOD_I};
      async_sy_ff <= {SUPPLY_LOW_I, FIELD_LOW_I, BATTERY_LOST_I, NVM_CORR_I, NVM_UNCORR_I};
      async_q_ff  <= async_sy_ff;
      sclk_d_ff   <= sclk_sy_ff[1];
    end
  end

  wire sclk_s   = sclk_sy_ff[1];
  wire cs_n_s   = cs_sy_ff[1];
  wire mosi_s   = mosi_sy_ff[1];
  wire sup_good = sg_sy_ff[1];
  wire sclk_rise = sclk_s & ~sclk_d_ff;
  wire sclk_fall = ~sclk_s & sclk_d_ff;

  // power-up initialization
  angle_readout_pkg::phase_e phase_ff;
  logic [31:0]               init_cnt_ff;
  wire init_done = (init_cnt_ff == INIT_CYC - 1);

  always_ff @(posedge MCLK_I or negedge NRST_I)
  begin
    if (!NRST_I)
    begin
      phase_ff    <= angle_readout_pkg::ST_INIT;
      init_cnt_ff <= 32'h0;
    end
    else if (CE_I)
    begin
      case (phase_ff)
        angle_readout_pkg::ST_INIT:
        begin
          init_cnt_ff <= init_cnt_ff + 32'h1;
          if (init_done)
            phase_ff <= angle_readout_pkg::ST_RUN;
        end
        angle_readout_pkg::ST_RUN: phase_ff <= angle_readout_pkg::ST_RUN;
        default: phase_ff <= angle_readout_pkg::ST_INIT;
      endcase
    end
  end

  wire running = (phase_ff == angle_readout_pkg::ST_RUN);
  wire serial_ok = running & sup_good;

  // configuration registers, defaults from nonvolatile image
  logic        slow_ff;
  logic [2:0]  averaging_select_ff;
  logic [12:0] ref_ff;
  logic        cfg_loaded_ff;

  // refresh timer
  logic [31:0] per_cnt_ff;
  wire  [31:0] period_cyc = slow_ff ? (32'(BASE_CYC) << averaging_select_ff)
                                    : 32'(BASE_CYC);
  wire         per_tick = running & (per_cnt_ff >= period_cyc - 32'h1);

  always_ff @(posedge MCLK_I or negedge NRST_I)
  begin
    if (!NRST_I)
      per_cnt_ff <= 32'h0;
    else if (CE_I)
      per_cnt_ff <= per_tick ? 32'h0 : per_cnt_ff + 32'h1;
  end

  // watchdog: front-end tick must arrive within the window
  logic [31:0] wdog_ff;
  logic        ifault_ff;
  always_ff @(posedge MCLK_I or negedge NRST_I)
  begin
    if (!NRST_I)
    begin
      wdog_ff   <= 32'h0;
      ifault_ff <= 1'b0;
    end
    else if (CE_I && running)
    begin
      wdog_ff <= CONV_TICK_I ? 32'h0 : wdog_ff + 32'h1;
      if (wdog_ff >= WDOG_CYC - 1)
        ifault_ff <= 1'b1;
    end
  end

  // sample capture with diagnostics
  angle_readout_pkg::diag_s diag_now;
  angle_readout_pkg::diag_s diag_ff;
  logic [12:0]              angle_ff;
  logic                     batt_seen_ff;
  logic                     corr_seen_ff;
  logic                     uncorr_seen_ff;
  logic                     flag_clr;

  assign diag_now.supply_low          = async_q_ff[4];
  assign diag_now.magnet_lost_flag    = async_q_ff[3];
  assign diag_now.internal_fault_flag = ifault_ff;
  assign diag_now.battery_loss_flag   = batt_seen_ff | async_q_ff[2];
  assign diag_now.nvm_corrected       = corr_seen_ff | async_q_ff[1];
  assign diag_now.nvm_uncorrectable   = uncorr_seen_ff | async_q_ff[0];

  always_ff @(posedge MCLK_I or negedge NRST_I)
  begin
    if (!NRST_I)
    begin
      batt_seen_ff   <= 1'b0;
      corr_seen_ff   <= 1'b0;
      uncorr_seen_ff <= 1'b0;
    end
    else if (CE_I)
    begin
      // set wins over a simultaneous clear
      batt_seen_ff   <= async_q_ff[2] | (batt_seen_ff & ~flag_clr);
      corr_seen_ff   <= async_q_ff[1] | (corr_seen_ff & ~flag_clr);
      uncorr_seen_ff <= async_q_ff[0] | (uncorr_seen_ff & ~flag_clr);
    end
  end

  always_ff @(posedge MCLK_I or negedge NRST_I)
  begin
    if (!NRST_I)
    begin
      angle_ff <= 13'h0000;
      diag_ff  <= '0;
    end
    else if (CE_I && per_tick)
    begin
      angle_ff <= RAW_ANGLE_I - ref_ff;
      diag_ff  <= diag_now;
    end
  end

  // spi slave: frame of 16 bits, mode 0, msb first
  logic [15:0] rx_ff;
  logic [15:0] tx_ff;
  logic [4:0]  bit_cnt_ff;
  logic [3:0]  rd_addr_ff;
  logic        sw_wr;
  logic [15:0] resp_word;
  logic        spi_wr_ff;
  logic [15:0] spi_wdata_ff;
  logic        miso_ff;
  wire         frame_end = (bit_cnt_ff == 5'h0F) & sclk_rise;
  wire  [15:0] rx_full = {rx_ff[14:0], mosi_s};

  // answer of a register index
  function automatic logic [15:0] reg_word(input logic [3:0] idx,
                                           input logic [12:0] ang,
                                           input angle_readout_pkg::diag_s d,
                                           input logic sl, input logic [2:0] av,
                                           input logic [12:0] rf);
    logic [15:0] w;
    w = 16'h0000;
    case (idx)
      `REG_ANGLE:     w = {d.supply_low, d.internal_fault_flag, d.magnet_lost_flag, ang};
      `REG_STATUS:    w = {10'h000, d};
      `REG_CTRL:      w = {12'h000, av[0], sl, av[2:1]};
      `REG_REF_ANGLE: w = {3'h0, rf};
      default:        w = 16'h0000;
    endcase
    return w;
  endfunction

  assign resp_word = reg_word(rd_addr_ff, angle_ff, diag_ff, slow_ff,
                              averaging_select_ff, ref_ff);

  always_ff @(posedge MCLK_I or negedge NRST_I)
  begin
    if (!NRST_I)
    begin
      rx_ff        <= 16'h0000;
      tx_ff        <= 16'h0000;
      bit_cnt_ff   <= 5'h00;
      rd_addr_ff   <= 4'h0;
      spi_wr_ff    <= 1'b0;
      spi_wdata_ff <= 16'h0000;
      miso_ff      <= 1'b0;
    end
    else if (CE_I)
    begin
      spi_wr_ff <= 1'b0;
      if (cs_n_s || !serial_ok)
      begin
        bit_cnt_ff <= 5'h00;
        tx_ff      <= resp_word;
        miso_ff    <= resp_word[15];
      end
      else
      begin
        if (sclk_rise)
        begin
          rx_ff      <= rx_full;
          bit_cnt_ff <= (bit_cnt_ff == 5'h0F) ? 5'h00 : bit_cnt_ff + 5'h01;
        end
        if (sclk_fall)
        begin
          tx_ff   <= {tx_ff[14:0], 1'b0};
          miso_ff <= tx_ff[14];
        end
        if (frame_end)
        begin
          // bit 15 set means write, bits 14:11 the register index
          if (rx_full[15])
          begin
            spi_wr_ff    <= 1'b1;
            spi_wdata_ff <= rx_full;
          end
          else
            rd_addr_ff <= rx_full[14:11];
        end
      end
    end
  end

  assign MISO_O    = miso_ff;
  assign MISO_OE_O = ~cs_n_s & serial_ok;

  // avalon slave: one wait cycle on every access
  logic        ack_ff;
  logic [31:0] rdata_ff;
  wire         avs_req = AVS_READ_I | AVS_WRITE_I;
  wire         avs_do  = avs_req & ~ack_ff;
  // writes land on the completing edge, when waitrequest is already low
  wire         avs_fin = avs_req & ack_ff;
  wire [3:0]   avs_idx = (AVS_ADDRESS_I == `ADDR_ANGLE)  ? `REG_ANGLE :
                         (AVS_ADDRESS_I == `ADDR_STATUS) ? `REG_STATUS :
                         (AVS_ADDRESS_I == `ADDR_CTRL)   ? `REG_CTRL :
                         (AVS_ADDRESS_I == `ADDR_REF)    ? `REG_REF_ANGLE : 4'hF;
  wire         avs_wr_ctrl = avs_fin & AVS_WRITE_I & (AVS_ADDRESS_I == `ADDR_CTRL);
  wire         avs_wr_ref  = avs_fin & AVS_WRITE_I & (AVS_ADDRESS_I == `ADDR_REF);
  wire         avs_wr_stat = avs_fin & AVS_WRITE_I & (AVS_ADDRESS_I == `ADDR_STATUS);
  wire [15:0]  avs_word = reg_word(avs_idx, angle_ff, diag_ff, slow_ff,
                                   averaging_select_ff, ref_ff);
  wire         spi_ctrl = spi_wr_ff & (spi_wdata_ff[14:11] == `REG_CTRL);
  wire         spi_ref  = spi_wr_ff & (spi_wdata_ff[14:11] == `REG_REF_ANGLE);
  assign flag_clr = avs_wr_stat & AVS_WRITEDATA_I[0];

  always_ff @(posedge MCLK_I or negedge NRST_I)
  begin
    if (!NRST_I)
    begin
      ack_ff   <= 1'b0;
      rdata_ff <= 32'h0;
    end
    else if (CE_I)
    begin
      ack_ff <= avs_do;
      if (avs_do && AVS_READ_I)
        rdata_ff <= {16'h0000, avs_word};
    end
  end

  assign AVS_WAITREQUEST_O = avs_req & ~ack_ff;
  assign AVS_READDATA_O    = rdata_ff;

  // configuration: reset to zero with averaging at AVERAGING_RESET, nonvolatile image loaded on the first enabled cycle after reset
  always_ff @(posedge MCLK_I or negedge NRST_I)
  begin
    if (!NRST_I)
    begin
      slow_ff       <= 1'b0;
      averaging_select_ff <= `AVERAGING_RESET;
      ref_ff        <= 13'h0000;
      cfg_loaded_ff <= 1'b0;
    end
    else if (CE_I)
    begin
      if (!cfg_loaded_ff)
      begin
        slow_ff       <= NVM_SLOW;
        averaging_select_ff <= NVM_AVERAGING;
        ref_ff        <= NVM_REF;
        cfg_loaded_ff <= 1'b1;
      end
      else if (spi_ctrl)
      begin
        slow_ff <= spi_wdata_ff[`CTRL_SLOW_BIT];
        averaging_select_ff <= {spi_wdata_ff[1:0], spi_wdata_ff[3]};
      end
      else if (avs_wr_ctrl)
      begin
        slow_ff <= AVS_WRITEDATA_I[`CTRL_SLOW_BIT];
        averaging_select_ff <= {AVS_WRITEDATA_I[1:0], AVS_WRITEDATA_I[3]};
      end
      else if (spi_ref)
        ref_ff <= spi_wdata_ff[12:0];
      else if (avs_wr_ref)
        ref_ff <= AVS_WRITEDATA_I[12:0];
    end
  end

  assign READY_O     = running;
  assign SLOW_MODE_O = slow_ff;

endmodule

/* testbench/angle_sensor_readout_properties.sv */
// port checker for the angle sensor readout
`timescale 1ns/1ps
module angle_sensor_readout_properties #(
  parameter int   INIT_CYC = 50,
  parameter int   WDOG_CYC = 64,
  parameter int   BASE_CYC = 20,
  parameter logic NVM_SLOW = 1'b0
) (
  // clock and reset
  input wire logic        MCLK_I,
  input wire logic        NRST_I,
  // inputs
  input wire logic        CONV_TICK_I,
  input wire logic        SUPPLY_GOOD_I,
  input wire logic        CS_N_I,
  input wire logic [3:0]  AVS_ADDRESS_I,
  input wire logic        AVS_READ_I,
  input wire logic        AVS_WRITE_I,
  input wire logic [31:0] AVS_WRITEDATA_I,
  // outputs
  input wire logic [31:0] AVS_READDATA_O,
  input wire logic        AVS_WAITREQUEST_O,
  input wire logic        MISO_OE_O,
  input wire logic        READY_O,
  input wire logic        SLOW_MODE_O
);
  logic [15:0] up_ff;
  logic [15:0] idle_ff;
  wire         req  = AVS_READ_I | AVS_WRITE_I;
  wire         acc  = req & ~AVS_WAITREQUEST_O;
  wire         wbit = AVS_WRITEDATA_I[2];
  wire         ctlw = acc & AVS_WRITE_I & (AVS_ADDRESS_I == 4'h4);
  wire         str  = acc & AVS_READ_I & (AVS_ADDRESS_I == 4'h8);
  // longest quiet time before the fault must show: init, watchdog, one slowest refresh
  wire  [31:0] wlim = INIT_CYC + WDOG_CYC + (SLOW_MODE_O ? 32'h80 : 32'h1) * BASE_CYC + 8;
  // cycles since reset and since the last front-end tick, both saturating
  always_ff @(posedge MCLK_I or negedge NRST_I)
    if (!NRST_I)
      up_ff <= 16'h0000;
    else if (up_ff != 16'hFFFF)
      up_ff <= up_ff + 16'h0001;
  always_ff @(posedge MCLK_I or negedge NRST_I)
    if (!NRST_I)
      idle_ff <= 16'h0000;
    else
      idle_ff <= CONV_TICK_I ? 16'h0000 : idle_ff + {15'h0000, idle_ff != 16'hFFFF};
  default clocking dc @(posedge MCLK_I);
  endclocking
  default disable iff (!NRST_I);
  a_ready_early: assert property (up_ff < INIT_CYC - 1 |-> !READY_O)
    else $error("ready before init end");
  a_ready_late: assert property (up_ff == INIT_CYC + 4 |-> READY_O)
    else $error("ready missing after init");
  a_mode_nvm: assert property (up_ff == 16'h0002 |-> SLOW_MODE_O == NVM_SLOW)
    else $error("mode not from memory");
  a_lockout_quiet: assert property (!SUPPLY_GOOD_I [*4] |-> !MISO_OE_O)
    else $error("driving under lockout");
  a_init_quiet: assert property (!READY_O |-> !MISO_OE_O)
    else $error("driving during init");
  a_idle_cs: assert property (CS_N_I [*4] |-> !MISO_OE_O)
    else $error("driving while deselected");
  a_one_wait: assert property (req & AVS_WAITREQUEST_O |=> !AVS_WAITREQUEST_O)
    else $error("wait longer than one cycle");
  a_upper_zero: assert property (acc & AVS_READ_I |-> AVS_READDATA_O[31:16] == 16'h0000)
    else $error("upper read bits set");
  a_ctrl_slow: assert property (ctlw |=> SLOW_MODE_O == $past(wbit))
    else $error("mode bit not taken");
  a_wdog_flag: assert property (str && idle_ff > wlim |-> AVS_READDATA_O[4])
    else $error("watchdog flag missing");
  c_frame: cover property ($fell(CS_N_I) ##[1:20] MISO_OE_O);
  c_slow: cover property ($rose(SLOW_MODE_O));
  c_wdog: cover property (str && AVS_READDATA_O[4]);
endmodule
bind angle_sensor_readout angle_sensor_readout_properties #(
  .INIT_CYC(INIT_CYC), .WDOG_CYC(WDOG_CYC), .BASE_CYC(BASE_CYC), .NVM_SLOW(NVM_SLOW)
) u_angle_sensor_readout_properties (
  .MCLK_I(MCLK_I), .NRST_I(NRST_I), .CONV_TICK_I(CONV_TICK_I),
  .SUPPLY_GOOD_I(SUPPLY_GOOD_I), .CS_N_I(CS_N_I), .AVS_ADDRESS_I(AVS_ADDRESS_I),
  .AVS_READ_I(AVS_READ_I), .AVS_WRITE_I(AVS_WRITE_I), .AVS_WRITEDATA_I(AVS_WRITEDATA_I),
  .AVS_READDATA_O(AVS_READDATA_O), .AVS_WAITREQUEST_O(AVS_WAITREQUEST_O),
  .MISO_OE_O(MISO_OE_O), .READY_O(READY_O), .SLOW_MODE_O(SLOW_MODE_O));

/* testbench/angle_sensor_readout_tb.sv */
// self-checking bench for the angle sensor readout
`timescale 1ns/1ps
module angle_sensor_readout_tb;
  localparam int          BASE = 20;
  localparam int          WDOG = 64;
  localparam logic [12:0] NREF = 13'h0005;
  logic        mclk, nrst, tick, tick_en, fld, sg, sl, bat, ncor, nunc;
  logic        rd, wr, wreq, miso, oe, sclk, cs_n, mosi, rdy, slow;
  logic [3:0]  adr;
  logic [12:0] raw;
  logic [31:0] wdat, rdat;
  int          err_count = 0, num_checks = 0, cyc = 0;
  angle_sensor_readout #(.INIT_CYC(50), .BASE_CYC(BASE), .WDOG_CYC(WDOG),
    .NVM_REF(NREF), .NVM_SLOW(1'b0), .NVM_AVERAGING(3'h1)) u_angle_sensor_readout (
    .MCLK_I(mclk), .NRST_I(nrst), .CE_I(1'b1), .RAW_ANGLE_I(raw), .CONV_TICK_I(tick),
    .FIELD_LOW_I(fld), .SUPPLY_GOOD_I(sg), .SUPPLY_LOW_I(sl), .BATTERY_LOST_I(bat),
    .NVM_CORR_I(ncor), .NVM_UNCORR_I(nunc), .SCLK_I(sclk), .CS_N_I(cs_n),
    .MOSI_I(mosi), .MISO_O(miso), .MISO_OE_O(oe), .AVS_ADDRESS_I(adr),
    .AVS_READ_I(rd), .AVS_WRITE_I(wr), .AVS_WRITEDATA_I(wdat), .AVS_READDATA_O(rdat),
    .AVS_WAITREQUEST_O(wreq), .READY_O(rdy), .SLOW_MODE_O(slow));
  spi_host_model u_spi_host_model (.clk_i(mclk), .miso_i(miso), .miso_oe_i(oe), .sclk_o(sclk),
    .cs_n_o(cs_n), .mosi_o(mosi));
  always #4 mclk = ~mclk;
  always @(posedge mclk)
  begin
    cyc <= cyc + 1;
    tick <= tick_en & (cyc[3:0] == 4'h0);
    if (cyc == 20000)
    begin
      err_count++;
      give_verdict();
    end
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e)
    begin
      $display("wrong value %s expected %h seen %h", nm, e, g);
      err_count++;
    end
  endtask
  task automatic give_verdict();
    if (err_count == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] wd,
                     output logic [31:0] d);
    int n;
    n = 0;
    @(posedge mclk);
    adr <= a;
    wdat <= wd;
    rd <= !w;
    wr <= w;
    @(posedge mclk);
    while (wreq !== 1'b0 && n < 50)
    begin
      @(posedge mclk);
      n++;
    end
    if (n == 50)
      err_count++;
    d = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  task automatic do_reset();
    int n;
    n = 0;
    @(posedge mclk);
    nrst <= 1'b0;
    repeat (2) @(posedge mclk);
    nrst <= 1'b1;
    while (rdy !== 1'b1 && n < 200)
    begin
      @(negedge mclk);
      n++;
    end
    chk("ready", 32'h1, {31'h0, rdy});
  endtask
  task automatic rd_chk(input string nm, input logic [3:0] a, input logic [31:0] e);
    logic [31:0] d;
    bus(1'b0, a, 32'h0, d);
    chk(nm, e, d);
  endtask
  task automatic t_defaults();
    logic [31:0] d;
    rd_chk("ctrl", 4'h4, 32'h8);
    rd_chk("ref", 4'hC, {19'h0, NREF});
    bus(1'b1, 4'h2, 32'hFFFF, d);
    rd_chk("unmapped", 4'h2, 32'h0);
    rd_chk("status", 4'h8, 32'h0);
  endtask
  task automatic meas(output int n);
    logic [31:0] d;
    int t0;
    raw <= raw + 13'h0001;
    t0 = cyc;
    do
      bus(1'b0, 4'h0, 32'h0, d);
    while (d[12:0] !== raw - NREF && cyc - t0 < 500);
    n = cyc - t0;
  endtask
  task automatic t_period(input logic [31:0] cw, input int p);
    logic [31:0] d;
    int n;
    bus(1'b1, 4'h4, cw, d);
    @(posedge mclk);
    chk("mode", {31'h0, cw[2]}, {31'h0, slow});
    meas(n);
    meas(n);
    chk("period", 32'h1, {31'h0, n >= p - 8 && n <= p + 8});
  endtask
  task automatic t_flags();
    raw <= 13'h0003;
    {sl, fld, bat, ncor, nunc} <= 5'h1F;
    repeat (2 * BASE + 4) @(posedge mclk);
    rd_chk("angle", 4'h0, 32'hBFFE);
    rd_chk("status", 4'h8, 32'h2F);
    {sl, fld, bat, ncor, nunc} <= 5'h0;
    repeat (2 * BASE + 4) @(posedge mclk);
    rd_chk("angle", 4'h0, 32'h1FFE);
    rd_chk("sticky", 4'h8, 32'h7);
    rd_chk("sticky", 4'h8, 32'h7);
  endtask
  task automatic t_spi();
    logic [15:0] r;
    logic [31:0] d;
    u_spi_host_model.xfer(16'h0000, r);
    u_spi_host_model.xfer(16'h0800, r);
    chk("spi angle", {19'h0, raw - NREF}, {16'h0, r});
    u_spi_host_model.xfer(16'h9004, r);
    chk("spi status", 32'h7, {16'h0, r});
    u_spi_host_model.xfer(16'h1000, r);
    u_spi_host_model.xfer(16'h0000, r);
    chk("spi ctrl", 32'h4, {16'h0, r});
    bus(1'b1, 4'h8, 32'h1, d);
    repeat (2 * BASE + 4) @(posedge mclk);
    rd_chk("cleared", 4'h8, 32'h0);
  endtask
  task automatic t_lockout();
    logic [15:0] r;
    @(posedge mclk);
    sg <= 1'b0;
    repeat (4) @(posedge mclk);
    u_spi_host_model.xfer(16'h9000, r);
    chk("lockout miso", 32'hFFFF, {16'h0, r});
    chk("lockout mode", 32'h1, {31'h0, slow});
    @(posedge mclk);
    sg <= 1'b1;
  endtask
  task automatic t_watchdog();
    logic [31:0] d;
    bus(1'b1, 4'h4, 32'h0, d);
    tick_en <= 1'b0;
    repeat (WDOG + 2 * BASE + 80) @(posedge mclk);
    rd_chk("watchdog", 4'h8, 32'h10);
    tick_en <= 1'b1;
    repeat (2 * BASE + 4) @(posedge mclk);
    rd_chk("fault angle", 4'h0, {19'h2, raw - NREF});
    do_reset();
    t_defaults();
  endtask
  initial
  begin
    {mclk, nrst, tick, fld, sl, bat, ncor, nunc, rd, wr} = 10'h0;
    {tick_en, sg} = 2'h3;
    {raw, adr, wdat} = 49'h0;
    do_reset();
    t_defaults();
    t_period(32'h5, 4 * BASE);
    t_period(32'h0, BASE);
    t_flags();
    t_spi();
    t_lockout();
    t_watchdog();
    give_verdict();
  end
endmodule

/* testbench/spi_host_model.sv */
// host side of the serial link
`timescale 1ns/1ps
module spi_host_model (
  // bench clock
  input  wire logic clk_i,
  // from the die
  input  wire logic miso_i,
  input  wire logic miso_oe_i,
  // to the die
  output logic      sclk_o,
  output logic      cs_n_o,
  output logic      mosi_o
);
  initial
  begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    mosi_o = 1'b0;
  end
  // one frame, five clocks per half period; a released data line reads as the pull-up
  task automatic xfer(input logic [15:0] cmd, output logic [15:0] rsp);
    @(posedge clk_i);
    cs_n_o <= 1'b0;
    mosi_o <= cmd[15];
    for (int i = 15; i >= 0; i--)
    begin
      repeat (5) @(posedge clk_i);
      sclk_o <= 1'b1;
      rsp[i] = miso_oe_i ? miso_i : 1'b1;
      repeat (5) @(posedge clk_i);
      sclk_o <= 1'b0;
      if (i > 0)
        mosi_o <= cmd[i - 1];
    end
    repeat (5) @(posedge clk_i);
    cs_n_o <= 1'b1;
    mosi_o <= ~mosi_o;
    repeat (12) @(posedge clk_i);
  endtask
endmodule
